// ==== hw/windowed_watchdog_timer.sv ====
// Operation
// - Counter advances only on low-speed oscillator ticks, not on system clock.
// - Writing ACH to the key register clears counter and restarts counting.
// - Writing any other value to the key register raises internal reset.
// - Single-bit write to the key register raises internal reset; reads do not.
// - Key faults while source clock stopped are held until it runs.
// - Key register reads return its reset value, never written data.
// - Key reset value is 1AH with counting disabled, 9AH enabled.
// - Enable option starts counting and access checks; zero keeps both off.
// - Window size from option bits 6:5, overflow select from bits 3:1.
// - First key write after reset clears counter regardless of window.
// - Later key writes in the closed window raise internal reset.
// - Overflow without valid key write raises internal reset.
// - Instruction fetch outside configured region raises internal reset.
// - Access outside region raises reset, except FB00H to FFFFH.
// - Watchdog reset sets bit 4 of the reset cause flags.
// - Overflow time after a clear deviates by less than one slow period.
// - Key write just before terminal count still clears the counter.
// - Oscillator-lock zero stops counting in HALT and STOP; one continues.
// - After HALT or STOP the count resumes from its retained value.
// - Oscillator stop bit with lock zero halts counter, keeping count.
// - Overflow select n gives 2^(10+n) slow ticks.
// - Window field 00..11 opens last 25, 50, 75 or 100 percent.
module windowed_watchdog_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic slow_osc_tick,
  input wire logic [7:0] option_byte,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  output logic internal_reset
);

  wdt_pkg::opt_s cfg;
  wdt_pkg::limits_s lim;

  logic load_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic osc_stop_q;
  logic [15:0] mem_limit_q;
  logic wdt_flag_q;
  logic [wdt_pkg::CNT_W-1:0] count_q;
  logic first_done_q;
  logic pend_q;
  logic guard_fault;

  logic addr_phase;
  logic key_wr;
  logic bit_wr;
  logic key_ok;
  logic window_open;
  logic src_run;
  logic running;
  logic closed_wr;
  logic key_fault;
  logic key_clear;
  logic overflow;
  logic fire;
  logic [7:0] key_read;
  logic [31:0] rd_d;

  option_latch u_option_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(load_q),
    .option_byte(option_byte),
    .cfg(cfg),
    .lim(lim)
  );

  access_guard u_access_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(cfg.enable && !load_q),
    .region_limit(mem_limit_q),
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .acc_valid(acc_valid),
    .acc_addr(acc_addr),
    .fault_q(guard_fault)
  );

  // Bus address phase and write decode
  assign addr_phase = hsel && hready && htrans[1];
  assign key_wr = wr_pend_q && (wr_addr_q == wdt_pkg::KEY_ADDR);
  assign bit_wr = wr_pend_q && (wr_addr_q == wdt_pkg::KEY_BITOP_ADDR);
  assign key_ok = (hwdata[7:0] == wdt_pkg::KEY_CODE);

  // Source clock state
  assign src_run = cfg.osc_lock || !(halt_mode || stop_mode || osc_stop_q);
  assign running = cfg.enable && !load_q && src_run;
  assign window_open = (count_q >= lim.close_limit);

  // Fault and clear events
  assign closed_wr = key_wr && key_ok && cfg.enable && first_done_q && !window_open;
  assign key_fault = (key_wr && !key_ok) || bit_wr || closed_wr;
  assign key_clear = key_wr && key_ok && !closed_wr && !load_q;
  assign overflow = running && slow_osc_tick && !key_clear &&
                    (count_q == lim.ovf_limit);
  assign fire = overflow || (pend_q && src_run) || guard_fault;

  // Reset value seen on key reads
  assign key_read = cfg.enable ? wdt_pkg::KEY_READ_ON : wdt_pkg::KEY_READ_OFF;

  always_comb begin
    rd_d = '0;
    unique case (haddr)
      wdt_pkg::KEY_ADDR: rd_d = {24'h00_0000, key_read};
      wdt_pkg::OSC_MODE_ADDR: rd_d[wdt_pkg::OSC_STOP_BIT] = osc_stop_q;
      wdt_pkg::MEM_SIZE_ADDR: rd_d = {16'h0000, mem_limit_q};
      wdt_pkg::RESET_CAUSE_ADDR: rd_d[wdt_pkg::WDT_FLAG_BIT] = wdt_flag_q;
      wdt_pkg::STATUS_ADDR: rd_d = {12'h000, first_done_q, window_open, pend_q, count_q};
      default: rd_d = '0;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Option reload request after any reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_q <= 1'b1;
    end else begin
      load_q <= fire;
    end
  end

  // Oscillator stop control bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_stop_q <= 1'b0;
    end else if (fire) begin
      osc_stop_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == wdt_pkg::OSC_MODE_ADDR) begin
      osc_stop_q <= hwdata[wdt_pkg::OSC_STOP_BIT];
    end
  end

  // Memory region limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_limit_q <= wdt_pkg::MEM_LIMIT_RESET;
    end else if (fire) begin
      mem_limit_q <= wdt_pkg::MEM_LIMIT_RESET;
    end else if (wr_pend_q && wr_addr_q == wdt_pkg::MEM_SIZE_ADDR) begin
      mem_limit_q <= hwdata[15:0];
    end
  end

  // Reset cause flag: write one to clear, a new watchdog reset wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_flag_q <= 1'b0;
    end else if (fire) begin
      wdt_flag_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == wdt_pkg::RESET_CAUSE_ADDR &&
                 hwdata[wdt_pkg::WDT_FLAG_BIT]) begin
      wdt_flag_q <= 1'b0;
    end
  end

  // Held key fault until source clock runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
    end else if (fire) begin
      pend_q <= 1'b0;
    end else if (key_fault) begin
      pend_q <= 1'b1;
    end
  end

  // Watchdog counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (fire || load_q) begin
      count_q <= '0;
    end else if (key_clear) begin
      count_q <= '0;
    end else if (running && slow_osc_tick) begin
      count_q <= count_q + 17'h0_0001;
    end
  end

  // First key write after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_done_q <= 1'b0;
    end else if (fire || load_q) begin
      first_done_q <= 1'b0;
    end else if (key_clear) begin
      first_done_q <= 1'b1;
    end
  end

  // Internal reset pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= fire;
    end
  end

endmodule : windowed_watchdog_timer

// ==== hw/wdt_pkg.sv ====
package wdt_pkg;

  // Restart key register: printed offset is its index, byte address is four times it
  localparam logic [31:0] KEY_INDEX = 32'h0000_FF99;
  localparam logic [31:0] KEY_ADDR = {KEY_INDEX[29:0], 2'b00};
  // Control and status registers
  localparam logic [31:0] OSC_MODE_ADDR = 32'h0000_0100;
  localparam logic [31:0] MEM_SIZE_ADDR = 32'h0000_0104;
  localparam logic [31:0] RESET_CAUSE_ADDR = 32'h0000_0108;
  localparam logic [31:0] KEY_BITOP_ADDR = 32'h0000_010C;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0110;

  // Key values
  localparam logic [7:0] KEY_CODE = 8'hAC;
  localparam logic [7:0] KEY_READ_ON = 8'h9A;
  localparam logic [7:0] KEY_READ_OFF = 8'h1A;

  // Option byte field positions
  localparam int OPT_LOCK_BIT = 0;
  localparam int OPT_SEL_LO = 1;
  localparam int OPT_SEL_HI = 3;
  localparam int OPT_ENABLE_BIT = 4;
  localparam int OPT_SPAN_LO = 5;
  localparam int OPT_SPAN_HI = 6;

  // Register fields
  localparam int OSC_STOP_BIT = 1;
  localparam int WDT_FLAG_BIT = 4;
  localparam logic [15:0] MEM_LIMIT_RESET = 16'h8000;
  localparam logic [15:0] ALWAYS_OK_BASE = 16'hFB00;

  // Counter sizing
  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] BASE_PERIOD = 17'h0_0400;

  typedef struct packed {
    logic [1:0] open_span;
    logic enable;
    logic [2:0] ovf_sel;
    logic osc_lock;
  } opt_s;

  typedef struct packed {
    logic [CNT_W-1:0] ovf_limit;
    logic [CNT_W-1:0] close_limit;
  } limits_s;

endpackage : wdt_pkg

// ==== hw/option_latch.sv ====
module option_latch (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [7:0] option_byte,
  output wdt_pkg::opt_s cfg,
  output wdt_pkg::limits_s lim
);

  logic [wdt_pkg::CNT_W-1:0] period;
  logic [wdt_pkg::CNT_W-1:0] quarter;

  // Option byte caught on a clocked load after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '0;
    end else if (load) begin
      cfg.open_span <= option_byte[wdt_pkg::OPT_SPAN_HI:wdt_pkg::OPT_SPAN_LO];
      cfg.enable <= option_byte[wdt_pkg::OPT_ENABLE_BIT];
      cfg.ovf_sel <= option_byte[wdt_pkg::OPT_SEL_HI:wdt_pkg::OPT_SEL_LO];
      cfg.osc_lock <= option_byte[wdt_pkg::OPT_LOCK_BIT];
    end
  end

  // Period of 2^(10+n) slow ticks; at n=7 it wraps to zero and the limit wraps to all ones
  assign period = wdt_pkg::BASE_PERIOD << cfg.ovf_sel;
  // Quarter built from the base so the top select keeps its window
  assign quarter = (wdt_pkg::BASE_PERIOD >> 2) << cfg.ovf_sel;

  always_comb begin
    lim.ovf_limit = period - 17'h0_0001;
    unique case (cfg.open_span)
      2'b00: lim.close_limit = quarter + (quarter << 1);
      2'b01: lim.close_limit = quarter << 1;
      2'b10: lim.close_limit = quarter;
      2'b11: lim.close_limit = '0;
    endcase
  end

endmodule : option_latch

// ==== hw/access_guard.sv ====
module access_guard (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [15:0] region_limit,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  output logic fault_q
);

  logic fetch_bad;
  logic acc_bad;

  assign fetch_bad = fetch_valid && (fetch_addr >= region_limit);
  assign acc_bad = acc_valid && (acc_addr >= region_limit) &&
                   (acc_addr < wdt_pkg::ALWAYS_OK_BASE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= enable && (fetch_bad || acc_bad);
    end
  end

endmodule : access_guard

// ==== tb/wdt_sva.sv ====
module wdt_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] option_byte,
  input wire logic halt_mode,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  input wire logic internal_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take_q;
  logic w_q;
  logic seen_q;
  logic [31:0] a_q;
  logic en;
  logic bad_key;
  assign en = option_byte[wdt_pkg::OPT_ENABLE_BIT];
  assign bad_key = take_q && w_q && a_q == wdt_pkg::KEY_ADDR && hwdata[7:0] != wdt_pkg::KEY_CODE;
  // Address phase tracking and watchdog reset history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      take_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= '0;
      seen_q <= 1'b0;
    end else begin
      take_q <= hsel && hready && htrans[1];
      w_q <= hwrite;
      a_q <= haddr;
      seen_q <= seen_q || internal_reset;
    end
  end
  pulse_one_a:
    assert property (internal_reset |=> !internal_reset) else $error("reset pulse too long");
  key_read_a:
    assert property (take_q && !w_q && a_q == wdt_pkg::KEY_ADDR |->
      hrdata == (en ? 32'h0000_009A : 32'h0000_001A)) else $error("key read value wrong");
  bad_key_a:
    assert property (bad_key && option_byte[0] |-> ##[1:2] internal_reset)
      else $error("bad key gave no reset");
  bit_access_a:
    assert property (take_q && w_q && a_q == wdt_pkg::KEY_BITOP_ADDR && option_byte[0] |->
      ##[1:2] internal_reset) else $error("bit access gave no reset");
  fetch_out_a:
    assert property (fetch_valid && fetch_addr >= 16'h8000 && en |-> ##[1:4] internal_reset)
      else $error("stray fetch gave no reset");
  acc_out_a:
    assert property (acc_valid && acc_addr >= 16'h8000 && acc_addr < 16'hFB00 && en |->
      ##[1:4] internal_reset) else $error("stray access gave no reset");
  cause_flag_a:
    assert property (take_q && !w_q && a_q == wdt_pkg::RESET_CAUSE_ADDR && seen_q |->
      hrdata[4]) else $error("cause flag clear");
  held_fault_a:
    assert property ((bad_key && !option_byte[0] && halt_mode) ##1 halt_mode[*3] |->
      !internal_reset) else $error("fault fired while stopped");
endmodule : wdt_sva

bind windowed_watchdog_timer wdt_sva chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .option_byte, .halt_mode, .fetch_valid,
  .fetch_addr, .acc_valid, .acc_addr, .internal_reset);

// ==== tb/cpu_side.sv ====
module cpu_side (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go_fetch,
  input wire logic go_acc,
  input wire logic [15:0] addr,
  output logic slow_osc_tick,
  output logic fetch_valid,
  output logic acc_valid,
  output logic [15:0] fetch_addr,
  output logic [15:0] acc_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] div_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_q <= '0;
    else div_q <= div_q + 16'h0001;
  end
  // Slow oscillator ticks once per four system clocks
  assign slow_osc_tick = div_q[1:0] == 2'b00;
  assign fetch_valid = go_fetch;
  assign acc_valid = go_acc;
  // Idle address lines wander instead of holding the last value
  assign fetch_addr = go_fetch ? addr : ~div_q;
  assign acc_addr = go_acc ? addr : div_q;
endmodule : cpu_side

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [7:0] opt = 8'h31;
  logic halt = 1'b0;
  logic stop = 1'b0;
  logic go_f = 1'b0;
  logic go_a = 1'b0;
  logic [15:0] cpu_addr = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, tick, fv, av, irst;
  logic [15:0] fa, aa;
  logic [31:0] n_rst = '0;
  logic [31:0] e_rst = '0;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  logic rd_ph = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 51417;
  always #20 hclk = ~hclk;
  windowed_watchdog_timer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .slow_osc_tick(tick), .option_byte(opt), .halt_mode(halt), .stop_mode(stop),
    .fetch_valid(fv), .fetch_addr(fa), .acc_valid(av), .acc_addr(aa), .internal_reset(irst));
  cpu_side far_cpu (.hclk, .hresetn, .go_fetch(go_f), .go_acc(go_a), .addr(cpu_addr),
    .slow_osc_tick(tick), .fetch_valid(fv), .acc_valid(av), .fetch_addr(fa), .acc_addr(aa));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, '0);
  endtask : rd
  task automatic exp_rst(input logic [31:0] inc);
    repeat (8) @(posedge hclk);
    e_rst = e_rst + inc;
    chk("resets", n_rst, e_rst);
  endtask : exp_rst
  task automatic cpu(input logic f, input logic [15:0] a);
    @(posedge hclk);
    go_f <= f;
    go_a <= !f;
    cpu_addr <= a;
    @(posedge hclk);
    go_f <= 1'b0;
    go_a <= 1'b0;
  endtask : cpu
  task automatic do_reset(input logic [7:0] o);
    @(posedge hclk);
    hresetn <= 1'b0;
    opt <= o;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset
  // Output watcher: read data and reset pulses
  always @(posedge hclk) begin
    cyc++;
    if (irst === 1'b1) n_rst <= n_rst + 1;
    if (rd_ph) chk("hrdata", hrdata, exp_q.pop_front());
    if (rd_ph) chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (cyc > 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(wdt_pkg::KEY_ADDR, 32'h0000_009A);
    rd(32'h0000_0200, 32'h0);
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_00AC);
    exp_rst(0);
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_00AC);
    exp_rst(1);
    rd(wdt_pkg::RESET_CAUSE_ADDR, 32'h0000_0010);
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_00AC);
    repeat (2400) @(posedge hclk);
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_00AC);
    exp_rst(0);
    repeat (4040) @(posedge hclk);
    exp_rst(0);
    repeat (56) @(posedge hclk);
    exp_rst(1);
    v = $random(seed);
    if (v[7:0] == 8'hAC) v[0] = ~v[0];
    ahb(1'b1, wdt_pkg::KEY_ADDR, v);
    exp_rst(1);
    ahb(1'b1, wdt_pkg::KEY_BITOP_ADDR, 32'h0000_00AC);
    exp_rst(1);
    repeat (4) begin
      v = $random(seed);
      cpu(1'b1, v[15:0] & 16'h7FFF);
      exp_rst(0);
    end
    cpu(1'b1, 16'h9000);
    exp_rst(1);
    cpu(1'b0, 16'hFC00);
    exp_rst(0);
    cpu(1'b0, 16'h9000);
    exp_rst(1);
    do_reset(8'h30);
    halt <= 1'b1;
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_0055);
    exp_rst(0);
    halt <= 1'b0;
    exp_rst(1);
    ahb(1'b1, wdt_pkg::OSC_MODE_ADDR, 32'h0000_0002);
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_00AC);
    rd(wdt_pkg::STATUS_ADDR, 32'h0008_0000);
    repeat (100) @(posedge hclk);
    rd(wdt_pkg::STATUS_ADDR, 32'h0008_0000);
    ahb(1'b1, wdt_pkg::OSC_MODE_ADDR, 32'h0000_0000);
    stop <= 1'b1;
    ahb(1'b1, wdt_pkg::KEY_ADDR, 32'h0000_0055);
    exp_rst(0);
    stop <= 1'b0;
    exp_rst(1);
    do_reset(8'h21);
    rd(wdt_pkg::KEY_ADDR, 32'h0000_001A);
    cpu(1'b1, 16'h9000);
    exp_rst(0);
    tally_and_finish();
  end
endmodule : tb
